// [sfsr_top.sv]
// status register bank of the serial flash: flags, write latch and status writes
// Functional notes
// - failed byte in program/erase sets error flag
// - aborted program/erase leaves error flag clear
// - error flag refreshed after every program/erase
// - status bit mirrors protect pin level
// - summary field shows none, some, all protected
// - summary codes 00, 01, 11; 10 reserved
// - write-class commands rejected while latch clear
// - latch clear at power-up and reset
// - latch clears when write-class commands finish/abort
// - incomplete opcode abort keeps the latch
// - soft reset honoured only with reset enable
// - reset enable changed only by status write two
// - lockdown commands ignored unless lockdown enabled
// - lockdown enable survives soft reset and every operation other than freeze and status write two
// - freeze forces lockdown enable low until reset
// - busy high during program/erase, host polls
// - opcode 01h then one byte, extras ignored
// - data bit 7 lock, bits 5:2 global
// - chip select release updates lock, clears latch
// - global action from bits 5:2, prior lock
// - partial byte aborts, lock kept, latch cleared
// - protect pin low: lock may only set
// - only lock bit changed by status write
`timescale 1ns/1ns
`default_nettype none
module sfsr_top
  import sfsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  input wire logic busy_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic op_abort_i,
  input wire logic all_protected_i,
  input wire logic some_protected_i,
  output logic so_o,
  output logic so_oe_o,
  output logic cmd_go_o,
  output logic [7:0] cmd_opcode_o,
  output logic global_protect_o,
  output logic global_unprotect_o,
  output logic soft_reset_o,
  output logic prot_lock_o,
  output logic write_enable_o,
  output logic reset_enable_o,
  output logic lockdown_enable_o,
  output logic [7:0] status_one_o,
  output logic [7:0] status_two_o
);
  sfsr_frame_t frame;
  logic pub_ack;
  logic [N_SYNC-1:0] async_in;
  logic [N_SYNC-1:0] level;

  sfsr_state_t state_reg, state_next;
  logic hold_abort_reg, hold_abort_next;
  logic wel_reg, wel_next;
  logic protection_table_lock_bit_reg, protection_table_lock_bit_next;
  logic epe_reg, epe_next;
  logic reset_enable_bit_reg, reset_enable_bit_next;
  logic sle_reg, sle_next;
  logic frozen_reg, frozen_next;
  logic go_reg, go_next;
  logic [7:0] op_reg, op_next;
  logic gp_reg, gp_next;
  logic gu_reg, gu_next;
  logic srst_reg, srst_next;
  logic [7:0] st1_reg, st1_next;
  logic [7:0] st2_reg, st2_next;
  sfsr_status_t pub_reg, pub_next;
  logic pub_req_reg, pub_req_next;
  logic [1:0] software_protection_summary;
  logic opc_full, on_bound, data_full, wp_low;

  sfsr_link u_link (
    .link_clk_i(link_clk_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .pub_i(pub_reg),
    .pub_req_i(pub_req_reg),
    .pub_ack_o(pub_ack),
    .frame_o(frame),
    .so_o(so_o),
    .so_oe_o(so_oe_o)
  );

  assign async_in = {pub_ack, hold_n_i, wp_n_i, cs_n_i};

  // three-stage synchronisers; a change counts once stages two and three agree
  for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
    logic [2:0] sync_reg, sync_next;
    logic level_reg, level_next;
    always_comb begin
      sync_next = {sync_reg[1:0], async_in[g]};
      level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
    end
    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        sync_reg <= {3{SYNC_RST[g]}};
        level_reg <= SYNC_RST[g];
      end else begin
        sync_reg <= sync_next;
        level_reg <= level_next;
      end
    end
    assign level[g] = level_reg;
  end

  assign wp_low = ~level[IX_WP];

  // frame tracking: link registers are frozen once chip select is seen high
  always_comb begin
    state_next = state_reg;
    hold_abort_next = hold_abort_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!level[IX_CS]) begin
          state_next = ST_FRAME;
          hold_abort_next = 1'b0;
        end
      end
      ST_FRAME: begin
        if (!level[IX_HOLD]) hold_abort_next = 1'b1;
        if (level[IX_CS]) state_next = ST_DECODE;
      end
      ST_DECODE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      hold_abort_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_abort_reg <= hold_abort_next;
    end
  end

  assign opc_full = frame.bytes != BYTES_NONE;
  assign on_bound = frame.bit_idx == BIT_FIRST;
  assign data_full = frame.bytes == BYTES_DATA && on_bound;

  // command decode at the end of each frame
  always_comb begin
    wel_next = wel_reg;
    protection_table_lock_bit_next = protection_table_lock_bit_reg;
    reset_enable_bit_next = reset_enable_bit_reg;
    sle_next = sle_reg;
    frozen_next = frozen_reg;
    go_next = 1'b0;
    op_next = op_reg;
    gp_next = 1'b0;
    gu_next = 1'b0;
    srst_next = 1'b0;
    if (state_reg == ST_DECODE) begin
      if (hold_abort_reg) begin
        wel_next = 1'b0;
      end else if (opc_full) begin
        case (frame.opcode)
          OP_WRITE_ENABLE: begin
            if (on_bound) wel_next = 1'b1;
          end
          OP_WRITE_DISABLE: begin
            if (on_bound) wel_next = 1'b0;
          end
          OP_WRITE_STATUS1: begin
            wel_next = 1'b0;
            // bits 6 and 1:0 of the data byte are ignored
            if (wel_reg && data_full && !(wp_low && protection_table_lock_bit_reg && !frame.data[S1_LOCK])) begin
              protection_table_lock_bit_next = frame.data[S1_LOCK];
              if (!protection_table_lock_bit_reg) begin
                gp_next = frame.data[GP_HI:GP_LO] == GP_PROTECT;
                gu_next = frame.data[GP_HI:GP_LO] == GP_UNPROTECT;
              end
            end
          end
          OP_WRITE_STATUS2: begin
            wel_next = 1'b0;
            if (wel_reg && data_full) begin
              reset_enable_bit_next = frame.data[S2_RESET_ENABLE_BIT];
              if (!frozen_reg) sle_next = frame.data[S2_SLE];
            end
          end
          OP_SOFT_RESET: begin
            if (reset_enable_bit_reg && data_full && frame.data == RESET_CONFIRM) begin
              srst_next = 1'b1;
              wel_next = 1'b0;
            end
          end
          default: begin
            if (sfsr_write_class(frame.opcode)) begin
              wel_next = 1'b0;
              if (wel_reg && on_bound &&
                  (sle_reg || !(frame.opcode inside {OP_LOCKDOWN, OP_FREEZE}))) begin
                go_next = 1'b1;
                op_next = frame.opcode;
                if (frame.opcode == OP_FREEZE) begin
                  frozen_next = 1'b1;
                  sle_next = 1'b0;
                end
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wel_reg <= 1'b0;
      protection_table_lock_bit_reg <= 1'b0;
      reset_enable_bit_reg <= 1'b0;
      sle_reg <= 1'b0;
      frozen_reg <= 1'b0;
      go_reg <= 1'b0;
      op_reg <= 8'h00;
      gp_reg <= 1'b0;
      gu_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      wel_reg <= wel_next;
      protection_table_lock_bit_reg <= protection_table_lock_bit_next;
      reset_enable_bit_reg <= reset_enable_bit_next;
      sle_reg <= sle_next;
      frozen_reg <= frozen_next;
      go_reg <= go_next;
      op_reg <= op_next;
      gp_reg <= gp_next;
      gu_reg <= gu_next;
      srst_reg <= srst_next;
    end
  end

  // error flag, status bytes and their publication to the serial side
  always_comb begin
    epe_next = epe_reg;
    if (op_done_i) epe_next = op_fail_i;
    if (op_abort_i) epe_next = 1'b0;
    if (all_protected_i) software_protection_summary = SWP_ALL;
    else if (some_protected_i) software_protection_summary = SWP_SOME;
    else software_protection_summary = SWP_NONE;
    st1_next = 8'h00;
    st1_next[S1_LOCK] = protection_table_lock_bit_reg;
    st1_next[S1_ERROR] = epe_reg;
    st1_next[S1_PIN] = level[IX_WP];
    st1_next[S1_SWP_HI:S1_SWP_LO] = software_protection_summary;
    st1_next[S1_WEL] = wel_reg;
    st1_next[ST_BUSY] = busy_i;
    st2_next = 8'h00;
    st2_next[S2_RESET_ENABLE_BIT] = reset_enable_bit_reg;
    st2_next[S2_SLE] = sle_reg;
    st2_next[ST_BUSY] = busy_i;
    pub_next = pub_reg;
    pub_req_next = pub_req_reg;
    if (pub_req_reg == level[IX_ACK] && pub_reg != {st1_reg, st2_reg}) begin
      pub_next = {st1_reg, st2_reg};
      pub_req_next = ~pub_req_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      epe_reg <= 1'b0;
      st1_reg <= 8'h00;
      st2_reg <= 8'h00;
      pub_reg <= '0;
      pub_req_reg <= 1'b0;
    end else begin
      epe_reg <= epe_next;
      st1_reg <= st1_next;
      st2_reg <= st2_next;
      pub_reg <= pub_next;
      pub_req_reg <= pub_req_next;
    end
  end

  assign cmd_go_o = go_reg;
  assign cmd_opcode_o = op_reg;
  assign global_protect_o = gp_reg;
  assign global_unprotect_o = gu_reg;
  assign soft_reset_o = srst_reg;
  assign prot_lock_o = protection_table_lock_bit_reg;
  assign write_enable_o = wel_reg;
  assign reset_enable_o = reset_enable_bit_reg;
  assign lockdown_enable_o = sle_reg;
  assign status_one_o = st1_reg;
  assign status_two_o = st2_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_wel_set_enable: assert property (
    state_reg == ST_DECODE && !hold_abort_reg && opc_full && on_bound && frame.opcode == OP_WRITE_ENABLE
    |=> wel_reg ##1 st1_reg[S1_WEL]) else $error("write enable did not set latch");
  a_wel_kept_short: assert property (
    state_reg == ST_DECODE && !hold_abort_reg && !opc_full |=> wel_reg == $past(wel_reg))
    else $error("latch changed on incomplete opcode");
  a_wel_class_clear: assert property (
    state_reg == ST_DECODE && opc_full && sfsr_write_class(frame.opcode) |=> !wel_reg)
    else $error("latch kept after write-class command");
  a_go_needs_wel: assert property (
    $rose(go_reg) |-> $past(wel_reg) && $past(state_reg) == ST_DECODE) else $error("command passed without latch");
  a_lock_abort_kept: assert property (
    state_reg == ST_DECODE && opc_full && frame.opcode == OP_WRITE_STATUS1 && !data_full
    |=> $stable(protection_table_lock_bit_reg) && !gp_reg && !gu_reg && !wel_reg) else $error("partial status write acted");
  a_lock_wp_guard: assert property (
    $fell(protection_table_lock_bit_reg) |-> $past(level[IX_WP], 1)) else $error("lock cleared while protect pin low");
  a_reset_gate: assert property (
    soft_reset_o |-> reset_enable_bit_reg && $past(reset_enable_bit_reg, 2)) else $error("soft reset without enable");
  a_freeze_sle_low: assert property (
    frozen_reg |-> !sle_reg ##1 !sle_reg) else $error("lockdown enable high after freeze");
  a_error_tracks: assert property (
    op_done_i && !op_abort_i |=> epe_reg == $past(op_fail_i) ##1 st1_reg[S1_ERROR] == $past(epe_reg))
    else $error("error flag not refreshed");
  a_swp_code: assert property (
    st1_reg[S1_SWP_HI:S1_SWP_LO] != SWP_RSVD) else $error("reserved protection summary code");
endmodule : sfsr_top
`default_nettype wire

// [sfsr_pkg.sv]
// shared constants and types of the flash status register block
package sfsr_pkg;
  localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_SOFT_RESET = 8'hf0;
  localparam logic [7:0] RESET_CONFIRM = 8'hd0;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_LOCKDOWN = 8'h33;
  localparam logic [7:0] OP_FREEZE = 8'h34;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9b;
  // status bit positions
  localparam int S1_LOCK = 7;
  localparam int S1_ERROR = 5;
  localparam int S1_PIN = 4;
  localparam int S1_SWP_HI = 3;
  localparam int S1_SWP_LO = 2;
  localparam int S1_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam int S2_RESET_ENABLE_BIT = 4;
  localparam int S2_SLE = 3;
  localparam int GP_HI = 5;
  localparam int GP_LO = 2;
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_RSVD = 2'h2;
  localparam logic [1:0] SWP_ALL = 2'h3;
  localparam logic [3:0] GP_PROTECT = 4'hf;
  localparam logic [3:0] GP_UNPROTECT = 4'h0;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_DATA = 2'h2;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // synchroniser lanes and their reset levels
  localparam int N_SYNC = 4;
  localparam int IX_CS = 0;
  localparam int IX_WP = 1;
  localparam int IX_HOLD = 2;
  localparam int IX_ACK = 3;
  localparam logic [N_SYNC-1:0] SYNC_RST = 4'h7;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic [1:0] bytes;
    logic [2:0] bit_idx;
  } sfsr_frame_t;
  typedef struct packed {
    logic [7:0] byte_one;
    logic [7:0] byte_two;
  } sfsr_status_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FRAME = 2'h1, ST_DECODE = 2'h3} sfsr_state_t;
  function automatic logic sfsr_write_class(input logic [7:0] op);
    return op inside {OP_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE,
                      OP_CHIP_ERASE_ALT, OP_PROTECT, OP_UNPROTECT, OP_LOCKDOWN, OP_FREEZE, OP_OTP_PROGRAM};
  endfunction : sfsr_write_class
endpackage : sfsr_pkg

// [sfsr_link.sv]
// serial-clock side: shifts in opcode and data, shifts out status bytes
`timescale 1ns/1ns
`default_nettype none
module sfsr_link
  import sfsr_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire sfsr_status_t pub_i,
  input wire logic pub_req_i,
  output logic pub_ack_o,
  output sfsr_frame_t frame_o,
  output logic so_o,
  output logic so_oe_o
);
  logic first_reg;
  logic [7:0] shift_reg, shift_next;
  sfsr_frame_t frame_reg, frame_next;
  logic [2:0] req_sync_reg, req_sync_next;
  logic req_reg, req_next;
  logic ack_reg, ack_next;
  sfsr_status_t snap_reg, snap_next;
  logic [7:0] out_reg, out_next;
  logic sel_reg, sel_next;
  logic oe_reg, oe_next;
  logic [2:0] idx;
  logic [1:0] nbytes;

  // marks the first edge of a frame; set while chip select is high
  always_ff @(posedge link_clk_i or posedge cs_n_i) begin
    if (cs_n_i) first_reg <= 1'b1;
    else first_reg <= 1'b0;
  end

  always_comb begin
    idx = first_reg ? BIT_FIRST : frame_reg.bit_idx;
    nbytes = first_reg ? BYTES_NONE : frame_reg.bytes;
    shift_next = {shift_reg[6:0], si_i};
    frame_next = frame_reg;
    frame_next.bit_idx = idx + 3'h1;
    frame_next.bytes = nbytes;
    if (idx == BIT_LAST) begin
      if (nbytes == BYTES_NONE) frame_next.opcode = shift_next;
      if (nbytes == BYTES_DATA - 2'h1) frame_next.data = shift_next;
      if (nbytes != BYTES_DATA) frame_next.bytes = nbytes + 2'h1;
    end
    req_sync_next = {req_sync_reg[1:0], pub_req_i};
    req_next = (req_sync_reg[1] == req_sync_reg[2]) ? req_sync_reg[2] : req_reg;
    // ack simply follows the request, so an unknown power-up level clears itself
    ack_next = req_reg;
    snap_next = snap_reg;
    if (req_reg != ack_reg) begin
      snap_next = pub_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    shift_reg <= shift_next;
    frame_reg <= frame_next;
    req_sync_reg <= req_sync_next;
    req_reg <= req_next;
    ack_reg <= ack_next;
    snap_reg <= snap_next;
  end

  // status bytes leave on falling edges, one then two, repeating
  always_comb begin
    out_next = {out_reg[6:0], 1'b0};
    sel_next = sel_reg;
    oe_next = oe_reg;
    if (!first_reg && frame_reg.bit_idx == BIT_FIRST && frame_reg.bytes != BYTES_NONE &&
        frame_reg.opcode == OP_READ_STATUS) begin
      out_next = sel_reg ? snap_reg.byte_two : snap_reg.byte_one;
      sel_next = ~sel_reg;
      oe_next = 1'b1;
    end
  end

  always_ff @(negedge link_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_reg <= 8'h00;
      sel_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      sel_reg <= sel_next;
      oe_reg <= oe_next;
    end
  end

  assign pub_ack_o = ack_reg;
  assign frame_o = frame_reg;
  assign so_o = out_reg[7];
  assign so_oe_o = oe_reg;
endmodule : sfsr_link
`default_nettype wire

// [sfsr_host.sv]
// host model of the serial link: frames, link clock and status reads
`timescale 1ns/1ns
`default_nettype none
module sfsr_host (
  output logic link_clk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // mode 0, msb first; the clock stands low between frames
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    #5 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      #32 link_clk_o = 1'b1;
      rx = {rx[30:0], so_oe_i ? so_i : 1'bx};
      #32 link_clk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    // released line shows the inverse of its last level
    si_o = ~si_o;
    // gap lets the frame be decoded before the next one
    #200;
  endtask : xfer
endmodule : sfsr_host
`default_nettype wire

// [sfsr_top_test.sv]
// self-checking bench of the status register bank
`timescale 1ns/1ns
`default_nettype none
module sfsr_top_test;
  import sfsr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i, link_clk_i, cs_n_i, si_i, wp_n_i, hold_n_i, busy_i;
  logic op_done_i, op_fail_i, op_abort_i, all_protected_i, some_protected_i;
  logic so_o, so_oe_o, cmd_go_o, global_protect_o, global_unprotect_o, soft_reset_o;
  logic prot_lock_o, write_enable_o, reset_enable_o, lockdown_enable_o;
  logic [7:0] cmd_opcode_o, status_one_o, status_two_o;
  logic [31:0] rx;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_go = 0;
  int n_gp = 0;
  int n_gu = 0;
  int n_sr = 0;
  localparam logic [1:0] SWP_EXP [4] = '{SWP_NONE, SWP_SOME, SWP_ALL, SWP_ALL};
  localparam logic [7:0] WR_OPS [9] = '{OP_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
    OP_CHIP_ERASE, OP_CHIP_ERASE_ALT, OP_PROTECT, OP_UNPROTECT, OP_OTP_PROGRAM};

  sfsr_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i), .cs_n_i(cs_n_i),
    .si_i(si_i), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .busy_i(busy_i), .op_done_i(op_done_i),
    .op_fail_i(op_fail_i), .op_abort_i(op_abort_i), .all_protected_i(all_protected_i),
    .some_protected_i(some_protected_i), .so_o(so_o), .so_oe_o(so_oe_o), .cmd_go_o(cmd_go_o),
    .cmd_opcode_o(cmd_opcode_o), .global_protect_o(global_protect_o),
    .global_unprotect_o(global_unprotect_o), .soft_reset_o(soft_reset_o), .prot_lock_o(prot_lock_o),
    .write_enable_o(write_enable_o), .reset_enable_o(reset_enable_o),
    .lockdown_enable_o(lockdown_enable_o), .status_one_o(status_one_o), .status_two_o(status_two_o));

  sfsr_host host (.link_clk_o(link_clk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_i(so_oe_o));

  always #4 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    if (cmd_go_o === 1'b1) n_go++;
    if (global_protect_o === 1'b1) n_gp++;
    if (global_unprotect_o === 1'b1) n_gu++;
    if (soft_reset_o === 1'b1) n_sr++;
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic cmd(input logic [31:0] tx, input int n);
    host.xfer(tx, n, rx);
    tick(1);
  endtask : cmd

  task automatic wen();
    cmd({24'h0, OP_WRITE_ENABLE}, 8);
  endtask : wen

  task automatic flags(input logic write_enable_latch, input logic lock);
    check({6'h0, write_enable_o, prot_lock_o}, {6'h0, write_enable_latch, lock});
  endtask : flags

  task automatic cnt(input int go, input int gp, input int gu, input int sr);
    check(8'(n_go), 8'(go));
    check({n_gp[1:0], n_gu[1:0], n_sr[3:0]}, {gp[1:0], gu[1:0], sr[3:0]});
  endtask : cnt

  task automatic evt(input logic done, input logic fail, input logic abort);
    {op_done_i, op_fail_i, op_abort_i} = {done, fail, abort};
    tick(1);
    {op_done_i, op_fail_i, op_abort_i} = 3'h0;
    tick(3);
  endtask : evt

  initial begin
    reset_i = 1'b1;
    {wp_n_i, hold_n_i, busy_i, op_done_i, op_fail_i, op_abort_i} = 6'h30;
    {all_protected_i, some_protected_i} = 2'h0;
    tick(16);
    reset_i = 1'b0;
    tick(8);
    check(status_one_o, 8'h10);
    check(status_two_o, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {all_protected_i, some_protected_i} = i[1:0];
      tick(3);
      check({6'h0, status_one_o[3:2]}, {6'h0, SWP_EXP[i]});
    end
    {all_protected_i, some_protected_i} = 2'h0;
    wp_n_i = 1'b0;
    tick(6);
    check({7'h0, status_one_o[4]}, 8'h00);
    wp_n_i = 1'b1;
    tick(6);
    // unknown opcode gives the link side eight clock edges so a status snapshot is posted
    cmd(32'h0, 8);
    host.xfer({OP_READ_STATUS, 24'h0}, 32, rx);
    check(rx[23:16], 8'h10);
    check(rx[15:8], 8'h00);
    wen();
    flags(1'b1, 1'b0);
    cmd(32'h0, 5);
    cmd(32'hff, 8);
    flags(1'b1, 1'b0);
    foreach (WR_OPS[i]) begin
      wen();
      cmd({24'h0, WR_OPS[i]}, 8);
      check(cmd_opcode_o, WR_OPS[i]);
      flags(1'b0, 1'b0);
    end
    cmd({24'h0, OP_PROGRAM}, 8);
    cnt(9, 0, 0, 0);
    wen();
    fork
      cmd({24'h0, OP_PROGRAM}, 8);
      begin
        tick(20);
        hold_n_i = 1'b0;
        tick(4);
        hold_n_i = 1'b1;
      end
    join
    flags(1'b0, 1'b0);
    cnt(9, 0, 0, 0);
    wen();
    cmd({24'h0, OP_WRITE_DISABLE}, 8);
    flags(1'b0, 1'b0);
    wen();
    cmd(32'h0180, 16);
    flags(1'b0, 1'b1);
    check(status_one_o, 8'h90);
    cnt(9, 0, 1, 0);
    wen();
    cmd(32'h013c, 16);
    cnt(9, 0, 1, 0);
    wen();
    cmd(32'h013c, 16);
    flags(1'b0, 1'b0);
    cnt(9, 1, 1, 0);
    wen();
    cmd(32'h018, 12);
    flags(1'b0, 1'b0);
    wen();
    cmd(32'h01808, 20);
    flags(1'b0, 1'b0);
    cnt(9, 1, 1, 0);
    wen();
    cmd(32'h0180ff, 24);
    flags(1'b0, 1'b1);
    wp_n_i = 1'b0;
    tick(6);
    wen();
    cmd(32'h0100, 16);
    flags(1'b0, 1'b1);
    wp_n_i = 1'b1;
    tick(6);
    cmd(32'h0100, 16);
    flags(1'b0, 1'b1);
    cnt(9, 1, 2, 0);
    evt(1'b1, 1'b1, 1'b0);
    check({7'h0, status_one_o[5]}, 8'h01);
    evt(1'b0, 1'b0, 1'b1);
    check({7'h0, status_one_o[5]}, 8'h00);
    evt(1'b1, 1'b1, 1'b0);
    evt(1'b1, 1'b0, 1'b0);
    check({7'h0, status_one_o[5]}, 8'h00);
    cmd(32'hf0d0, 16);
    cnt(9, 1, 2, 0);
    wen();
    cmd(32'h3110, 16);
    wen();
    cmd(32'hf0d0, 16);
    cnt(9, 1, 2, 1);
    check({5'h0, reset_enable_o, write_enable_o, prot_lock_o}, 8'h05);
    wen();
    cmd({24'h0, OP_LOCKDOWN}, 8);
    cnt(9, 1, 2, 1);
    wen();
    cmd(32'h3118, 16);
    cmd(32'hf0d0, 16);
    check({6'h0, reset_enable_o, lockdown_enable_o}, 8'h03);
    wen();
    cmd({24'h0, OP_LOCKDOWN}, 8);
    cnt(10, 1, 2, 2);
    wen();
    cmd({24'h0, OP_FREEZE}, 8);
    wen();
    cmd(32'h3118, 16);
    check({6'h0, reset_enable_o, lockdown_enable_o}, 8'h02);
    busy_i = 1'b1;
    tick(2);
    host.xfer({OP_READ_STATUS, 24'h0}, 32, rx);
    check({6'h0, rx[8], rx[0]}, 8'h03);
    busy_i = 1'b0;
    host.xfer({OP_READ_STATUS, 24'h0}, 32, rx);
    check(rx[7:0], 8'h90);
    check(rx[15:8], 8'h10);
    wrap_up();
  end
endmodule : sfsr_top_test
`default_nettype wire
